// file: txpa_ctl_if.sv
// control bundle between sequencer, symbol timer and gain ramp
`timescale 1ns/1ps
`default_nettype none
interface txpa_ctl_if;
    logic                            tmr_load;
    logic [txpa_pkg::TMR_W-1:0]      tmr_val;
    logic [txpa_pkg::TMR_W-1:0]      tmr_remain;
    logic                            ramp_run;
    logic                            ramp_down;
    logic [txpa_pkg::GAIN_W-1:0]     ramp_target;
    logic [txpa_pkg::GAIN_W-1:0]     ramp_gain;
    logic                            ramp_zero;
    modport seq  (output tmr_load, tmr_val, ramp_run, ramp_down, ramp_target,
                  input tmr_remain, ramp_gain, ramp_zero);
    modport tmr  (input tmr_load, tmr_val, output tmr_remain);
    modport ramp (input ramp_run, ramp_down, ramp_target, output ramp_gain, ramp_zero);
endinterface : txpa_ctl_if
`default_nettype wire

// file: txpa_frame_model.sv
// frame sender stand-in: answers each data start with one done pulse
`timescale 1ns/1ps
`default_nettype none
module txpa_frame_model (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       tx_data_start,
    input  wire logic [7:0] hold_cyc,
    output var  logic       tx_frame_done
);
    logic [7:0] cnt_q;
    // frame length countdown, done when it runs out
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_q <= 8'h00;
            tx_frame_done <= 1'b0;
        end else begin
            tx_frame_done <= (cnt_q == 8'h01);
            if (tx_data_start)
                cnt_q <= hold_cyc;
            else if (cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : txpa_frame_model
`default_nettype wire

// file: txpa_pkg.sv
// shared constants and types for the tx start and pa ramp sequencer
`default_nettype none
package txpa_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] REG_STATE_IDX = 6'h02;
    localparam logic [5:0] REG_POWER_IDX = 6'h05;
    localparam logic [5:0] REG_MODE_IDX  = 6'h0C;
    localparam logic [5:0] REG_RF_IDX    = 6'h16;
    // state register: command written in, status read out
    localparam int          CMD_W         = 5;
    localparam logic [4:0] CMD_TX_START  = 5'h02;
    localparam logic [4:0] STAT_READY    = 5'h09;
    localparam logic [4:0] STAT_BUSY_TX  = 5'h02;
    // power register fields
    localparam int          GAIN_W        = 3;
    localparam int          PWR_LEVEL_LSB = 0;
    localparam int          PWR_LEVEL_W   = 5;
    localparam int          PWR_GAIN_LSB  = 5;
    localparam logic [7:0] POWER_RST     = 8'h00;
    // rf control register fields
    localparam int          RF_LEAD_LSB   = 0;
    localparam int          RF_LEAD_W     = 3;
    localparam int          RF_OFFS_LSB   = 4;
    localparam int          RF_OFFS_W     = 2;
    localparam int          RF_BOOST_BIT  = 7;
    localparam logic [7:0] RF_RST        = 8'h00;
    // mode register fields
    localparam int          MODE_AACK_BIT = 0;
    localparam int          MODE_ARET_BIT = 1;
    localparam logic [7:0] MODE_RST      = 8'h00;
    // timing
    localparam int          TMR_W         = 16;
    localparam int          CLK_NS        = 10;
    localparam int          SYMBOL_NS     = 25000;
    localparam int          LEAD_STEP_NS  = 2000;
    localparam int          RAMP_STEP_NS  = 1000;
    localparam int          SYMBOL_CYC    = (SYMBOL_NS + CLK_NS - 1) / CLK_NS;
    localparam int          LEAD_STEP_CYC = (LEAD_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
    // sequencer states
    typedef enum logic [1:0] {
        ST_READY,
        ST_SETTLE,
        ST_SEND,
        ST_RAMPDN
    } txpa_state_t;
endpackage : txpa_pkg
`default_nettype wire

// file: txpa_ramp.sv
// pa gain stepper: up toward target while running, down to zero on request
`timescale 1ns/1ps
`default_nettype none
module txpa_ramp #(
    parameter int STEP_CYC = txpa_pkg::RAMP_STEP_CYC
) (
    input  wire logic  clk_sys,
    input  wire logic  reset,
    txpa_ctl_if.ramp   ctl
);
    localparam int CW = $clog2(STEP_CYC + 1);
    logic [txpa_pkg::GAIN_W-1:0] gain_q;
    logic [txpa_pkg::GAIN_W-1:0] gain_d;
    logic [CW-1:0]               tick_q;
    logic [CW-1:0]               tick_d;
    logic [txpa_pkg::GAIN_W-1:0] goal;

    // one gain step per step period; pa off holds gain at zero
    always_comb begin
        goal   = ctl.ramp_down ? '0 : ctl.ramp_target;
        gain_d = gain_q;
        tick_d = tick_q;
        if (!ctl.ramp_run) begin
            gain_d = '0;
            tick_d = '0;
        end else if (gain_q == goal) begin
            tick_d = '0;
        end else if (tick_q != CW'(STEP_CYC - 1)) begin
            tick_d = tick_q + 1'b1;
        end else begin
            tick_d = '0;
            gain_d = (gain_q < goal) ? gain_q + 1'b1 : gain_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gain_q <= '0;
            tick_q <= '0;
        end else begin
            gain_q <= gain_d;
            tick_q <= tick_d;
        end
    end

    assign ctl.ramp_gain = gain_q;
    assign ctl.ramp_zero = (gain_q == '0);
endmodule : txpa_ramp
`default_nettype wire

// file: txpa_seq.sv
// tx start and pa ramp sequencer with avalon-mm register slave
// Function
// - frame starts from ready on tx-start command or sleep/transmit pin rising edge
// - enabled auto-ack or auto-retry modes may launch a frame themselves
// - wait one symbol after start before data, synthesizer settles meanwhile
// - pa enabled before data by programmable lead time
// - pa starts at gain zero and steps up to programmed gain
// - after frame, ramp down in reverse order of ramp-up
// - reported state changes from ready to busy-tx on start
// - equalizer on by default, off in boost mode
// - output power field sets level in one-decibel steps
`timescale 1ns/1ps
`default_nettype none
module txpa_seq #(
    parameter int SYMBOL_CYC    = txpa_pkg::SYMBOL_CYC,
    parameter int LEAD_STEP_CYC = txpa_pkg::LEAD_STEP_CYC,
    parameter int RAMP_STEP_CYC = txpa_pkg::RAMP_STEP_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        sleep_transmit_pin,
    input  wire logic        auto_ack_launch,
    input  wire logic        auto_retry_launch,
    input  wire logic        tx_frame_done,
    output logic             synth_tx_select,
    output logic             pa_enable,
    output logic      [2:0]  pa_gain,
    output logic             pa_equalizer_en,
    output logic      [4:0]  tx_power_level,
    output logic      [1:0]  tx_gain_offset,
    output logic             tx_data_start,
    output logic             tx_busy
);
    txpa_ctl_if ctl ();

    txpa_timer txpa_timer_inst (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ctl     (ctl)
    );

    txpa_ramp #(
        .STEP_CYC (RAMP_STEP_CYC)
    ) txpa_ramp_inst (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ctl     (ctl)
    );

    // register slave
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [7:0]  power_q;
    logic [7:0]  power_d;
    logic [7:0]  rf_q;
    logic [7:0]  rf_d;
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic        wr_fire;
    logic        cmd_start;
    txpa_pkg::txpa_state_t state_q;

    // one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_fire         = avs_write & ack_q;
    assign avs_readdata    = rdata_q;

    // tx-start command accepted only in the ready state
    assign cmd_start = wr_fire && (avs_address == txpa_pkg::REG_STATE_IDX)
                       && (avs_writedata[txpa_pkg::CMD_W-1:0] == txpa_pkg::CMD_TX_START)
                       && (state_q == txpa_pkg::ST_READY);

    // write decode, read mux; unmapped reads give zero
    always_comb begin
        ack_d   = (avs_read | avs_write) & ~ack_q;
        power_d = power_q;
        rf_d    = rf_q;
        mode_d  = mode_q;
        rdata_d = rdata_q;
        if (wr_fire) begin
            unique case (avs_address)
                txpa_pkg::REG_POWER_IDX: power_d = avs_writedata[7:0];
                txpa_pkg::REG_RF_IDX:    rf_d    = avs_writedata[7:0];
                txpa_pkg::REG_MODE_IDX:  mode_d  = avs_writedata[7:0];
                default:                 ;
            endcase
        end
        if (avs_read & ~ack_q) begin
            unique case (avs_address)
                txpa_pkg::REG_STATE_IDX:
                    rdata_d = {27'h000_0000, (state_q == txpa_pkg::ST_READY) ?
                               txpa_pkg::STAT_READY : txpa_pkg::STAT_BUSY_TX};
                txpa_pkg::REG_POWER_IDX: rdata_d = {24'h00_0000, power_q};
                txpa_pkg::REG_RF_IDX:    rdata_d = {24'h00_0000, rf_q};
                txpa_pkg::REG_MODE_IDX:  rdata_d = {24'h00_0000, mode_q};
                default:                 rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            power_q <= txpa_pkg::POWER_RST;
            rf_q    <= txpa_pkg::RF_RST;
            mode_q  <= txpa_pkg::MODE_RST;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
            power_q <= power_d;
            rf_q    <= rf_d;
            mode_q  <= mode_d;
        end
    end

    // static pa settings
    logic [4:0] level_q;
    logic [1:0] offs_q;
    logic       eq_q;

    // power level, gain offset and equalizer follow the registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            level_q <= '0;
            offs_q  <= '0;
            eq_q    <= 1'b1;
        end else begin
            level_q <= power_q[txpa_pkg::PWR_LEVEL_LSB +: txpa_pkg::PWR_LEVEL_W];
            offs_q  <= rf_q[txpa_pkg::RF_OFFS_LSB +: txpa_pkg::RF_OFFS_W];
            eq_q    <= ~rf_q[txpa_pkg::RF_BOOST_BIT];
        end
    end

    assign tx_power_level  = level_q;
    assign tx_gain_offset  = offs_q;
    assign pa_equalizer_en = eq_q;

    // start sources
    logic pin_q;
    logic start;

    // pin edge, command, or launch from an enabled extended mode
    assign start = (state_q == txpa_pkg::ST_READY) &&
                   ((sleep_transmit_pin & ~pin_q) | cmd_start
                    | (auto_ack_launch & mode_q[txpa_pkg::MODE_AACK_BIT])
                    | (auto_retry_launch & mode_q[txpa_pkg::MODE_ARET_BIT]));

    // sequencer
    txpa_pkg::txpa_state_t       state_d;
    logic                        synth_q;
    logic                        synth_d;
    logic                        pa_q;
    logic                        pa_d;
    logic                        dstart_q;
    logic                        dstart_d;
    logic [txpa_pkg::TMR_W-1:0]  lead_cyc;

    // lead time in cycles from the pa lead-time field
    assign lead_cyc = txpa_pkg::TMR_W'(LEAD_STEP_CYC)
                      * txpa_pkg::TMR_W'(rf_q[txpa_pkg::RF_LEAD_LSB +: txpa_pkg::RF_LEAD_W]);

    always_comb begin
        state_d         = state_q;
        synth_d         = synth_q;
        pa_d            = pa_q;
        dstart_d        = 1'b0;
        ctl.tmr_load    = 1'b0;
        ctl.tmr_val     = txpa_pkg::TMR_W'(SYMBOL_CYC - 1);
        ctl.ramp_down   = 1'b0;
        ctl.ramp_target = power_q[txpa_pkg::PWR_GAIN_LSB +: txpa_pkg::GAIN_W];
        unique case (state_q)
            txpa_pkg::ST_READY: begin
                if (start) begin
                    state_d      = txpa_pkg::ST_SETTLE;
                    synth_d      = 1'b1;
                    ctl.tmr_load = 1'b1;
                end
            end
            txpa_pkg::ST_SETTLE: begin
                // pa turns on once the remaining settle time reaches the lead
                if (ctl.tmr_remain <= lead_cyc) begin
                    pa_d = 1'b1;
                end
                if (ctl.tmr_remain == '0) begin
                    state_d  = txpa_pkg::ST_SEND;
                    pa_d     = 1'b1;
                    dstart_d = 1'b1;
                end
            end
            txpa_pkg::ST_SEND: begin
                if (tx_frame_done) begin
                    state_d = txpa_pkg::ST_RAMPDN;
                end
            end
            txpa_pkg::ST_RAMPDN: begin
                // gain down first, then pa off, then synthesizer released
                ctl.ramp_down = 1'b1;
                if (pa_q && ctl.ramp_zero) begin
                    pa_d = 1'b0;
                end else if (!pa_q) begin
                    synth_d = 1'b0;
                    state_d = txpa_pkg::ST_READY;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q  <= txpa_pkg::ST_READY;
            synth_q  <= 1'b0;
            pa_q     <= 1'b0;
            dstart_q <= 1'b0;
            pin_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            synth_q  <= synth_d;
            pa_q     <= pa_d;
            dstart_q <= dstart_d;
            pin_q    <= sleep_transmit_pin;
        end
    end

    // ramp starts from zero whenever the pa is switched on
    assign ctl.ramp_run = pa_q;

    assign synth_tx_select = synth_q;
    assign pa_enable       = pa_q;
    assign pa_gain         = ctl.ramp_gain;
    assign tx_data_start   = dstart_q;
    assign tx_busy         = (state_q != txpa_pkg::ST_READY);
endmodule : txpa_seq
`default_nettype wire

// file: txpa_seq_properties.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module txpa_seq_checker #(
    parameter int SYMBOL_CYC = 20
) (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       synth_tx_select,
    input wire logic       pa_enable,
    input wire logic [2:0] pa_gain,
    input wire logic       tx_data_start,
    input wire logic       tx_busy
);
    localparam int DLO = SYMBOL_CYC - 7;
    localparam int DHI = SYMBOL_CYC - 5;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_start; $rose(tx_busy); endsequence
    sequence s_down; pa_gain == 3'h0 && synth_tx_select ##1 !synth_tx_select; endsequence
    property p_busy; s_start |-> synth_tx_select && !pa_enable; endproperty
    a_busy: assert property (p_busy) else $error("busy without synth");
    property p_settle; s_start |-> (!tx_data_start)[*8] ##[DLO:DHI] tx_data_start; endproperty
    a_settle: assert property (p_settle) else $error("settle gap wrong");
    property p_pa_lead; tx_data_start |-> pa_enable; endproperty
    a_pa_lead: assert property (p_pa_lead) else $error("data before pa");
    property p_pa_zero; $rose(pa_enable) |-> pa_gain == 3'h0; endproperty
    a_pa_zero: assert property (p_pa_zero) else $error("pa on above zero");
    property p_step; $changed(pa_gain) |-> pa_gain == $past(pa_gain) + 3'h1 || pa_gain == $past(pa_gain) - 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("gain jump");
    property p_pace; pa_gain != $past(pa_gain) |=> $stable(pa_gain); endproperty
    a_pace: assert property (p_pace) else $error("gain too fast");
    property p_gain_on; pa_gain != 3'h0 |-> pa_enable; endproperty
    a_gain_on: assert property (p_gain_on) else $error("gain while pa off");
    property p_down; $fell(pa_enable) |-> s_down; endproperty
    a_down: assert property (p_down) else $error("ramp down order");
    property p_ready; $fell(synth_tx_select) |-> ##[0:1] !tx_busy; endproperty
    a_ready: assert property (p_ready) else $error("not back to ready");
    property p_bus; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_bus: assert property (p_bus) else $error("bus wait wrong");
endmodule : txpa_seq_checker
`default_nettype wire

// file: txpa_seq_tb_top.sv
// self-checking bench for the tx start and pa ramp sequencer
`timescale 1ns/1ps
`default_nettype none
module txpa_seq_tb_top;
    localparam int SYM = 20;
    localparam int LST = 2;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [5:0]  addr = 6'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wait_r;
    logic        pin = 1'b0;
    logic        aack = 1'b0;
    logic        aret = 1'b0;
    logic        done;
    logic        synth;
    logic        pa_en;
    logic [2:0]  gain;
    logic        eq;
    logic [4:0]  lvl;
    logic [1:0]  offs;
    logic        dstart;
    logic        busy;
    logic [31:0] v;
    int          miscompares = 0;
    int          n_tests = 0;
    always #5 clk_sys = ~clk_sys;
    txpa_seq #(.SYMBOL_CYC(SYM), .LEAD_STEP_CYC(LST), .RAMP_STEP_CYC(2)) txpa_seq_inst (
        .clk_sys(clk_sys), .reset(reset), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_r), .sleep_transmit_pin(pin),
        .auto_ack_launch(aack), .auto_retry_launch(aret), .tx_frame_done(done), .synth_tx_select(synth),
        .pa_enable(pa_en), .pa_gain(gain), .pa_equalizer_en(eq), .tx_power_level(lvl),
        .tx_gain_offset(offs), .tx_data_start(dstart), .tx_busy(busy));
    txpa_frame_model txpa_frame_model_inst (.clk_sys(clk_sys), .reset(reset), .tx_data_start(dstart),
        .hold_cyc(8'h1E), .tx_frame_done(done));
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // waits for the slave answer, data taken where it stands
    task ack;
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (wait_r !== 1'b0 && i < 50);
        cmp(wait_r, 1'b0);
        v = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : ack
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= {24'h00_0000, d};
        wr_en <= 1'b1;
        ack();
    endtask : wr
    task rd(input logic [5:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        ack();
    endtask : rd
    task wait_busy(input logic lv);
        int i;
        i = 0;
        do begin
            @(negedge clk_sys);
            i++;
        end while (busy !== lv && i < 400);
        cmp(busy, lv);
    endtask : wait_busy
    // follows one frame from start to ready
    task watch_frame(input logic [2:0] tgt, input int lead);
        int n;
        int pa_n;
        logic [2:0] mx;
        n = 0;
        pa_n = -1;
        mx = 3'h0;
        wait_busy(1'b1);
        while (dstart !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
            if (pa_en === 1'b1 && pa_n < 0) pa_n = n;
        end
        cmp(n, SYM);
        cmp(n - pa_n, lead * LST);
        while (busy === 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
            if (gain > mx) mx = gain;
        end
        cmp(mx, tgt);
        cmp({pa_en, gain, synth}, 5'h00);
        rd(txpa_pkg::REG_STATE_IDX);
        cmp(v[4:0], txpa_pkg::STAT_READY);
    endtask : watch_frame
    task t_reset_values;
        logic [5:0] ra [5] = '{txpa_pkg::REG_STATE_IDX, txpa_pkg::REG_POWER_IDX, txpa_pkg::REG_MODE_IDX,
            txpa_pkg::REG_RF_IDX, 6'h3F};
        logic [7:0] re [5] = '{8'(txpa_pkg::STAT_READY), txpa_pkg::POWER_RST, txpa_pkg::MODE_RST,
            txpa_pkg::RF_RST, 8'h00};
        cmp(eq, 1'b1);
        foreach (ra[i]) begin
            rd(ra[i]);
            cmp(v, {24'h00_0000, re[i]});
        end
        $display("done reset_values");
    endtask : t_reset_values
    task t_cmd_frame;
        wr(txpa_pkg::REG_POWER_IDX, 8'h80);
        wr(txpa_pkg::REG_RF_IDX, 8'h33);
        repeat (2) @(negedge clk_sys);
        cmp(offs, 2'h3);
        wr(txpa_pkg::REG_STATE_IDX, 8'(txpa_pkg::CMD_TX_START));
        watch_frame(3'h4, 3);
        $display("done cmd_frame");
    endtask : t_cmd_frame
    task t_pin_frame;
        wr(txpa_pkg::REG_POWER_IDX, 8'hA0);
        wr(txpa_pkg::REG_RF_IDX, 8'h20);
        @(posedge clk_sys);
        pin <= 1'b1;
        watch_frame(3'h5, 0);
        @(posedge clk_sys);
        pin <= 1'b0;
        $display("done pin_frame");
    endtask : t_pin_frame
    task t_launch;
        wr(txpa_pkg::REG_MODE_IDX, 8'h00);
        @(posedge clk_sys);
        aack <= 1'b1;
        @(posedge clk_sys);
        aack <= 1'b0;
        repeat (5) @(negedge clk_sys);
        cmp(busy, 1'b0);
        wr(txpa_pkg::REG_MODE_IDX, 8'h01);
        @(posedge clk_sys);
        aack <= 1'b1;
        @(posedge clk_sys);
        aack <= 1'b0;
        wait_busy(1'b1);
        rd(txpa_pkg::REG_STATE_IDX);
        cmp(v[4:0], txpa_pkg::STAT_BUSY_TX);
        wr(txpa_pkg::REG_STATE_IDX, 8'(txpa_pkg::CMD_TX_START));
        wait_busy(1'b0);
        repeat (3) @(negedge clk_sys);
        cmp(busy, 1'b0);
        wr(txpa_pkg::REG_MODE_IDX, 8'h02);
        @(posedge clk_sys);
        aret <= 1'b1;
        @(posedge clk_sys);
        aret <= 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        $display("done launch");
    endtask : t_launch
    task t_boost_power;
        logic [7:0] code [6] = '{8'hC0, 8'hC1, 8'hE3, 8'hE9, 8'hEA, 8'hE4};
        wr(txpa_pkg::REG_RF_IDX, 8'h80);
        repeat (2) @(negedge clk_sys);
        cmp(eq, 1'b0);
        wr(txpa_pkg::REG_RF_IDX, 8'h00);
        repeat (2) @(negedge clk_sys);
        cmp(eq, 1'b1);
        foreach (code[i]) begin
            wr(txpa_pkg::REG_POWER_IDX, code[i]);
            rd(txpa_pkg::REG_POWER_IDX);
            cmp(v, {24'h00_0000, code[i]});
            cmp(lvl, code[i][4:0]);
        end
        $display("done boost_power");
    endtask : t_boost_power
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset_values();
        t_cmd_frame();
        t_pin_frame();
        t_launch();
        t_boost_power();
        wrap_up();
    end
    // watchdog against a hung handshake
    initial begin
        #60000;
        miscompares++;
        wrap_up();
    end
endmodule : txpa_seq_tb_top
bind txpa_seq txpa_seq_checker #(.SYMBOL_CYC(SYMBOL_CYC)) txpa_seq_checker_inst (.clk_sys(clk_sys),
    .reset(reset), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .synth_tx_select(synth_tx_select), .pa_enable(pa_enable), .pa_gain(pa_gain),
    .tx_data_start(tx_data_start), .tx_busy(tx_busy));
`default_nettype wire

// file: txpa_timer.sv
// down-counter that times the settling symbol
`timescale 1ns/1ps
`default_nettype none
module txpa_timer (
    input  wire logic  clk_sys,
    input  wire logic  reset,
    txpa_ctl_if.tmr    ctl
);
    logic [txpa_pkg::TMR_W-1:0] remain_q;
    logic [txpa_pkg::TMR_W-1:0] remain_d;

    // load on request, else count toward zero
    always_comb begin
        remain_d = remain_q;
        if (ctl.tmr_load) begin
            remain_d = ctl.tmr_val;
        end else if (remain_q != '0) begin
            remain_d = remain_q - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            remain_q <= '0;
        end else begin
            remain_q <= remain_d;
        end
    end

    assign ctl.tmr_remain = remain_q;
endmodule : txpa_timer
`default_nettype wire
